// ==== logic/pss_pkg.sv ====
// Constants and carrier types for the PHY status summary register bank.
// Assumes one 10 MHz clock domain shared by the bus and every flag source.
package pss_pkg;

    // Register indices as numbered in the map; byte address is index * 4
    localparam logic [7:0] IDX_SUMMARY   = 8'h10;
    localparam logic [7:0] IDX_FC_CNT    = 8'h14;
    localparam logic [7:0] IDX_RXERR_CNT = 8'h15;
    localparam int         ADDR_W        = 8;
    localparam logic [7:0] ADDR_SUMMARY   = {IDX_SUMMARY[5:0], 2'b00};
    localparam logic [7:0] ADDR_FC_CNT    = {IDX_FC_CNT[5:0], 2'b00};
    localparam logic [7:0] ADDR_RXERR_CNT = {IDX_RXERR_CNT[5:0], 2'b00};

    // Summary register field positions
    localparam int BIT_RXERR_LATCH = 13;
    localparam int BIT_POLARITY    = 12;
    localparam int BIT_FC_LATCH    = 11;
    localparam int BIT_SIG_DETECT  = 10;
    localparam int BIT_DESCR_LOCK  = 9;
    localparam int BIT_PAGE_RX     = 8;
    localparam int BIT_RSV7        = 7;
    localparam int BIT_REMOTE_FLT  = 6;
    localparam int BIT_JABBER      = 5;
    localparam int BIT_AN_DONE     = 4;
    localparam int BIT_LOOPBACK    = 3;
    localparam int BIT_DUPLEX      = 2;
    localparam int BIT_SPEED10     = 1;
    localparam int BIT_LINK        = 0;

    // Counter widths, limits and reset values
    localparam int         CNT_W     = 8;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX   = 8'hFF;
    localparam logic [7:0] CNT_ONE   = 8'h01;

    // AXI4-Lite response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Flags and events from the neighbouring PHY blocks, all on ref_clk
    typedef struct packed {
        logic rx_err_event;       // One-cycle pulse per receive error
        logic rx_collision;       // Level, collision during the error
        logic false_carrier_event;
        logic polarity_inverted;  // Level from ten_mbps_status_reg bit 4
        logic sig_detect;         // Live 100 Mb/s signal detect
        logic descram_lock;       // Live 100 Mb/s descrambler lock
        logic page_received;      // Level from autoneg_expansion_reg
        logic remote_fault_event; // Pulse, partner reported remote fault
        logic basic_status_rd;    // Pulse, basic_mode_status_reg was read
        logic jabber;
        logic autoneg_complete;
        logic loopback;
        logic full_duplex;
        logic speed_10;
        logic link_up;
    } pss_src_t;

    // Whole state of the block
    typedef struct packed {
        logic             aw_have;
        logic [7:0]       aw_addr;
        logic             w_have;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
        logic [CNT_W-1:0] rxerr_cnt;
        logic [CNT_W-1:0] fc_cnt;
        logic             rxerr_latch;
        logic             fc_latch;
        logic             sig_det_ll;
        logic             lock_ll;
        logic             remote_flt;
    } pss_state_t;

endpackage : pss_pkg

// ==== logic/pss_top.sv ====
// PHY status summary register bank with its two error counters.
// Assumes an AXI4-Lite master and flag sources on the same ref_clk.
// Summary of operation
// - Bits 15:14 read zero; writes to them are ignored.
// - Bit 13 latches high on any receive error since last counter read.
// - Bit 13 clears only on a read of the receive error counter.
// - Bit 12 mirrors the inverted-polarity flag of the 10 Mb/s status.
// - Polarity clears on its own register read, not on summary read.
// - Bit 11 latches high on any false carrier since last counter read.
// - Bit 11 clears only on a read of the false carrier counter.
// - Bit 10 is signal detect, latched low until the summary is read.
// - Bit 9 is descrambler lock, latched low until the summary is read.
// - Bit 8 mirrors page received; cleared by expansion register read only.
// - Bit 7 always reads zero; writes have no effect.
// - Bit 6 sets on partner remote fault; clears on basic status read or reset.
// - Bit 5 mirrors jabber detect; summary read does not clear it.
// - Bit 4 shows auto-negotiation complete.
// - Bit 3 shows loopback enabled.
// - Bit 2 shows resolved duplex, one for full.
// - Bit 1 shows resolved speed, one for 10 Mb/s.
// - Bit 0 mirrors link status; summary read does not clear it.
// - Receive error counter is 8 bits, clear on read, saturating, once per event outside a collision.
module pss_top
    import pss_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire pss_src_t           src
);

    pss_state_t s_q;
    pss_state_t s_d;
    logic [15:0] summary;
    logic        rd_fire;
    logic        wr_fire;
    logic        rd_summary;
    logic        rd_rxerr;
    logic        rd_fc;
    logic        wr_rxerr;
    logic        wr_fc;

    // Handshake outputs straight from the holding flags
    assign s_axi_awready = !s_q.aw_have;
    assign s_axi_wready  = !s_q.w_have;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;

    // Bus decode; read side effects happen at the address handshake
    assign rd_fire    = s_axi_arvalid && !s_q.rvalid;
    assign wr_fire    = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    assign rd_summary = rd_fire && (s_axi_araddr == ADDR_SUMMARY);
    assign rd_rxerr   = rd_fire && (s_axi_araddr == ADDR_RXERR_CNT);
    assign rd_fc      = rd_fire && (s_axi_araddr == ADDR_FC_CNT);
    assign wr_rxerr   = wr_fire && (s_q.aw_addr == ADDR_RXERR_CNT) && s_q.w_strb[0];
    assign wr_fc      = wr_fire && (s_q.aw_addr == ADDR_FC_CNT) && s_q.w_strb[0];

    // Summary image; mirrors are read live so their owners keep the clear
    always_comb begin
        summary                  = 16'h0000;
        summary[BIT_RXERR_LATCH] = s_q.rxerr_latch;
        summary[BIT_POLARITY]    = src.polarity_inverted;
        summary[BIT_FC_LATCH]    = s_q.fc_latch;
        summary[BIT_SIG_DETECT]  = s_q.sig_det_ll;
        summary[BIT_DESCR_LOCK]  = s_q.lock_ll;
        summary[BIT_PAGE_RX]     = src.page_received;
        summary[BIT_REMOTE_FLT]  = s_q.remote_flt;
        summary[BIT_JABBER]      = src.jabber;
        summary[BIT_AN_DONE]     = src.autoneg_complete;
        summary[BIT_LOOPBACK]    = src.loopback;
        summary[BIT_DUPLEX]      = src.full_duplex;
        summary[BIT_SPEED10]     = src.speed_10;
        summary[BIT_LINK]        = src.link_up;
    end

    // Next state of bus slave, counters and latches
    always_comb begin
        s_d = s_q;
        // Write address and data taken in either order
        if (s_axi_awvalid && !s_q.aw_have) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_have) begin
            s_d.w_have = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // Summary writes are accepted and dropped; it is read-only
        if (wr_fire) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            if ((s_q.aw_addr == ADDR_SUMMARY) || (s_q.aw_addr == ADDR_FC_CNT) ||
                (s_q.aw_addr == ADDR_RXERR_CNT)) begin
                s_d.bresp = RESP_OKAY;
            end else begin
                s_d.bresp = RESP_SLVERR;
            end
        end
        if (wr_rxerr) begin
            s_d.rxerr_cnt = s_q.w_data[CNT_W-1:0];
        end
        if (wr_fc) begin
            s_d.fc_cnt = s_q.w_data[CNT_W-1:0];
        end
        // Read answer
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            if (rd_summary) begin
                s_d.rdata = {16'h0000, summary};
            end else if (rd_rxerr) begin
                s_d.rdata = {24'h00_0000, s_q.rxerr_cnt};
                s_d.rxerr_cnt = CNT_RESET;
            end else if (rd_fc) begin
                s_d.rdata = {24'h00_0000, s_q.fc_cnt};
                s_d.fc_cnt = CNT_RESET;
            end else begin
                s_d.rresp = RESP_SLVERR;
            end
        end
        // Counters count after any clear, so a coincident event survives
        if (src.rx_err_event && !src.rx_collision && (s_d.rxerr_cnt != CNT_MAX)) begin
            s_d.rxerr_cnt = s_d.rxerr_cnt + CNT_ONE;
        end
        if (src.false_carrier_event && (s_d.fc_cnt != CNT_MAX)) begin
            s_d.fc_cnt = s_d.fc_cnt + CNT_ONE;
        end
        // Error latches: clear by counter read, set wins over clear
        if (rd_rxerr) begin
            s_d.rxerr_latch = 1'b0;
        end
        if (src.rx_err_event) begin
            s_d.rxerr_latch = 1'b1;
        end
        if (rd_fc) begin
            s_d.fc_latch = 1'b0;
        end
        if (src.false_carrier_event) begin
            s_d.fc_latch = 1'b1;
        end
        // Latched-low flags re-arm to the live level on a summary read
        if (rd_summary) begin
            s_d.sig_det_ll = src.sig_detect;
            s_d.lock_ll    = src.descram_lock;
        end else begin
            s_d.sig_det_ll = s_q.sig_det_ll && src.sig_detect;
            s_d.lock_ll    = s_q.lock_ll && src.descram_lock;
        end
        // Remote fault: basic status read clears, a new fault wins
        if (src.basic_status_rd) begin
            s_d.remote_flt = 1'b0;
        end
        if (src.remote_fault_event) begin
            s_d.remote_flt = 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Checks on the design's own behaviour
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence seq_rd_sum;
        rd_summary;
    endsequence

    sequence seq_rd_rx;
        rd_rxerr;
    endsequence

    sequence seq_rd_fc;
        rd_fc;
    endsequence

    sequence seq_rx_cnt;
        src.rx_err_event && !src.rx_collision;
    endsequence

    AST_RSV_ZERO: assert property (seq_rd_sum |=> (s_axi_rdata[31:14] == 18'h00000))
        else $error("reserved summary bits not zero");

    AST_BIT7_ZERO: assert property (seq_rd_sum |=> !s_axi_rdata[BIT_RSV7])
        else $error("summary bit 7 not zero");

    AST_RXERR_SET: assert property (src.rx_err_event |=> s_q.rxerr_latch)
        else $error("receive error latch did not set");

    AST_RXERR_KEEP: assert property (s_q.rxerr_latch && !rd_rxerr |=> s_q.rxerr_latch)
        else $error("receive error latch cleared without counter read");

    AST_RXERR_CLR: assert property (seq_rd_rx ##0 !src.rx_err_event |=> !s_q.rxerr_latch)
        else $error("receive error latch not cleared by counter read");

    AST_POL_MIRROR: assert property (seq_rd_sum |=>
                                     (s_axi_rdata[BIT_POLARITY] == $past(src.polarity_inverted)))
        else $error("polarity bit not mirrored");

    AST_FC_CLR: assert property (rd_fc && !src.false_carrier_event |=> !s_q.fc_latch)
        else $error("false carrier latch not cleared");

    AST_FC_SET: assert property (src.false_carrier_event ##1 !rd_fc |=> s_q.fc_latch)
        else $error("false carrier latch lost");

    AST_SD_LL: assert property (!src.sig_detect |=> !s_q.sig_det_ll)
        else $error("signal detect drop not latched");

    AST_LOCK_LL: assert property (!src.descram_lock ##1 !rd_summary |=> !s_q.lock_ll)
        else $error("descrambler lock drop not held");

    AST_RF_SET: assert property (src.remote_fault_event |=> s_q.remote_flt)
        else $error("remote fault did not set");

    AST_RF_CLR: assert property (src.basic_status_rd && !src.remote_fault_event
                                 |=> !s_q.remote_flt)
        else $error("remote fault not cleared by basic status read");

    AST_LINK: assert property (seq_rd_sum |=> (s_axi_rdata[BIT_LINK] == $past(src.link_up)))
        else $error("link bit not mirrored");

    AST_CNT_SAT: assert property ((s_q.rxerr_cnt == CNT_MAX) && !rd_rxerr && !wr_rxerr
                                  |=> (s_q.rxerr_cnt == CNT_MAX))
        else $error("receive error counter wrapped");

    AST_CNT_COR: assert property (seq_rd_rx ##0 !src.rx_err_event ##1 s_axi_rvalid
                                  |-> (s_q.rxerr_cnt == CNT_RESET))
        else $error("receive error counter not cleared on read");

    AST_NO_SIDE: assert property (rd_summary && !src.rx_err_event && !rd_rxerr && !wr_rxerr
                                  |=> $stable(s_q.rxerr_cnt) && (s_q.rxerr_latch
                                  == $past(s_q.rxerr_latch)))
        else $error("summary read disturbed counter or latch");

    AST_RD_ANSWER: assert property (rd_fire |=> s_axi_rvalid ##0 (s_axi_rresp
                                    == ($past(rd_summary || rd_rxerr || rd_fc)
                                    ? RESP_OKAY : RESP_SLVERR)))
        else $error("read answer missing or wrong response");

    // Summary image against its sources, one bit at a time
    AST_PAGE: assert property (seq_rd_sum |=>
        (s_axi_rdata[BIT_PAGE_RX] == $past(src.page_received)))
        else $error("page bit not mirrored");

    AST_JABBER: assert property (seq_rd_sum |=>
        (s_axi_rdata[BIT_JABBER] == $past(src.jabber)))
        else $error("jabber bit not mirrored");

    AST_AN_DONE: assert property (seq_rd_sum |=>
        (s_axi_rdata[BIT_AN_DONE] == $past(src.autoneg_complete)))
        else $error("autoneg bit not mirrored");

    AST_LOOPBACK: assert property (seq_rd_sum |=>
        (s_axi_rdata[BIT_LOOPBACK] == $past(src.loopback)))
        else $error("loopback bit not mirrored");

    AST_DUPLEX: assert property (seq_rd_sum |=>
        (s_axi_rdata[BIT_DUPLEX] == $past(src.full_duplex)))
        else $error("duplex bit not mirrored");

    AST_SPEED: assert property (seq_rd_sum |=>
        (s_axi_rdata[BIT_SPEED10] == $past(src.speed_10)))
        else $error("speed bit not mirrored");

    AST_RXERR_BIT: assert property (seq_rd_sum |=>
        (s_axi_rdata[BIT_RXERR_LATCH] == $past(s_q.rxerr_latch)))
        else $error("receive error bit wrong");

    AST_FC_BIT: assert property (seq_rd_sum |=>
        (s_axi_rdata[BIT_FC_LATCH] == $past(s_q.fc_latch)))
        else $error("false carrier bit wrong");

    AST_SD_BIT: assert property (seq_rd_sum |=>
        (s_axi_rdata[BIT_SIG_DETECT] == $past(s_q.sig_det_ll)))
        else $error("signal detect bit wrong");

    AST_RF_BIT: assert property (seq_rd_sum |=>
        (s_axi_rdata[BIT_REMOTE_FLT] == $past(s_q.remote_flt)))
        else $error("remote fault bit wrong");

    // Latches and counters; a summary read re-arms signal detect and descrambler lock and must leave the rest alone
    AST_FC_KEEP: assert property (s_q.fc_latch && !rd_fc
        |=> s_q.fc_latch)
        else $error("false carrier latch cleared without counter read");

    AST_RF_KEEP: assert property (s_q.remote_flt && !src.basic_status_rd
        |=> s_q.remote_flt)
        else $error("remote fault cleared without basic status read");

    AST_SD_HOLD: assert property (!s_q.sig_det_ll && !rd_summary
        |=> !s_q.sig_det_ll)
        else $error("signal detect low not held");

    AST_SD_REARM: assert property (seq_rd_sum ##0 src.sig_detect
        |=> s_q.sig_det_ll)
        else $error("signal detect not re-armed by summary read");

    AST_CNT_STEP: assert property (seq_rx_cnt ##0 (s_q.rxerr_cnt != CNT_MAX)
        ##0 !rd_rxerr && !wr_rxerr |=> (s_q.rxerr_cnt == $past(s_q.rxerr_cnt) + CNT_ONE))
        else $error("receive error counter did not step");

    AST_CNT_COLL: assert property (src.rx_err_event && src.rx_collision
        ##0 !rd_rxerr && !wr_rxerr |=> $stable(s_q.rxerr_cnt))
        else $error("receive error counted during collision");

    AST_RXCNT_READ: assert property (seq_rd_rx |=>
        (s_axi_rdata == {24'h00_0000, $past(s_q.rxerr_cnt)}))
        else $error("receive error counter read wrong");

    AST_FC_NO_SIDE: assert property (seq_rd_sum ##0 !src.false_carrier_event && !wr_fc
        |=> $stable(s_q.fc_cnt) && $stable(s_q.fc_latch))
        else $error("summary read disturbed false carrier state");

    AST_RF_NO_SIDE: assert property (seq_rd_sum ##0 !src.remote_fault_event
        ##0 !src.basic_status_rd |=> $stable(s_q.remote_flt))
        else $error("summary read disturbed remote fault");

    // Bus answers and the counter clear on read
    AST_WR_ANSWER: assert property (wr_fire
        |=> s_axi_bvalid)
        else $error("write answer missing");

    AST_UNMAPPED_RD: assert property (rd_fire && !rd_summary && !rd_rxerr && !rd_fc
        |=> (s_axi_rdata == 32'h0000_0000))
        else $error("unmapped read returned data");

    AST_FC_CNT_CLR: assert property (seq_rd_fc ##0 !src.false_carrier_event
        |=> (s_q.fc_cnt == CNT_RESET))
        else $error("false carrier counter not cleared on read");

    AST_SUM_WR_OK: assert property (wr_fire && (s_q.aw_addr == ADDR_SUMMARY)
        |=> (s_axi_bresp == RESP_OKAY))
        else $error("summary write not answered okay");

endmodule : pss_top

// ==== testbench/tb_pss_top.sv ====
// Self-checking bench for the PHY status summary register bank.
// Assumes pss_top on one 100 ns ref_clk; flag sources driven directly here.
module tb_pss_top
    import pss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              ref_clk;
    logic              rst;
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic              awready;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready;
    pss_src_t          src;
    int                err_total;
    int                cmp_count;
    logic [31:0]       rd;
    logic [1:0]        rs;
    int                src_pos [8] = '{11, 8, 5, 4, 3, 2, 1, 0};
    int                sum_pos [8] = '{12, 8, 5, 4, 3, 2, 1, 0};

    pss_top dut (
        .ref_clk(ref_clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .src(src)
    );

    // 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task complete_run;
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Hang guard, counts as a mismatch and ends the run
    task give_up;
        err_total++;
        $display("CHECK FAILED at %0t: handshake timed out", $time);
        complete_run();
    endtask : give_up

    // Ready is sampled at the falling edge, stable until the next rising one
    task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_p;
        logic w_p;
        logic a_r;
        logic w_r;
        int   n;
        aw_p = 1'b1;
        w_p  = 1'b1;
        @(posedge ref_clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hF;
        wvalid  <= 1'b1;
        for (n = 0; n < 50 && (aw_p || w_p); n++) begin
            @(negedge ref_clk);
            a_r = awready;
            w_r = wready;
            @(posedge ref_clk);
            if (a_r === 1'b1 && aw_p) begin
                awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_r === 1'b1 && w_p) begin
                wvalid <= 1'b0;
                w_p = 1'b0;
            end
        end
        if (aw_p || w_p) give_up();
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge ref_clk);
            a_r  = bvalid;
            resp = bresp;
            @(posedge ref_clk);
            if (a_r === 1'b1) break;
        end
        if (n == 50) give_up();
        bready <= 1'b0;
    endtask : axi_write

    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic r;
        int   n;
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge ref_clk);
            r = arready;
            @(posedge ref_clk);
            if (r === 1'b1) break;
        end
        if (n == 50) give_up();
        arvalid <= 1'b0;
        rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge ref_clk);
            r    = rvalid;
            d    = rdata;
            resp = rresp;
            @(posedge ref_clk);
            if (r === 1'b1) break;
        end
        if (n == 50) give_up();
        rready <= 1'b0;
    endtask : axi_read

    // One-cycle inversion of a source bit: a pulse on an event, a drop on a level
    task pulse(input int p, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            @(posedge ref_clk);
            src <= pss_src_t'(src ^ (15'h1 << p));
            @(posedge ref_clk);
            src <= pss_src_t'(src ^ (15'h1 << p));
        end
    endtask : pulse

    task do_reset;
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
    endtask : do_reset

    // Main sequence
    initial begin
        err_total = 0;
        cmp_count = 0;
        rst = 1'b1;
        awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0;
        bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0; src = '0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd, 32'h0);
        check(rs, RESP_OKAY);
        // Each live status alone, read twice to show a summary read does not clear it
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            src <= pss_src_t'(15'h1 << src_pos[i]);
            repeat (2) begin
                axi_read(ADDR_SUMMARY, rd, rs);
                check(rd, 32'h1 << sum_pos[i]);
            end
        end
        // Speed and duplex looked at again with link up and negotiation done
        @(posedge ref_clk);
        src <= pss_src_t'(15'h0017);
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd[4:0], 5'h17);
        // Latched-low detect and lock
        @(posedge ref_clk);
        src <= pss_src_t'(15'h0600);
        axi_read(ADDR_SUMMARY, rd, rs);
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd[10:9], 2'b11);
        pulse(10, 1);
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd[10:9], 2'b01);
        pulse(9, 1);
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd[10:9], 2'b10);
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd[10:9], 2'b11);
        // Receive error latch and counter
        pulse(14, 1);
        axi_read(ADDR_SUMMARY, rd, rs);
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd[13], 1'b1);
        axi_read(ADDR_FC_CNT, rd, rs);
        check(rd, 32'h0);
        axi_read(ADDR_RXERR_CNT, rd, rs);
        check(rd, 32'h1);
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd[13], 1'b0);
        axi_read(ADDR_RXERR_CNT, rd, rs);
        check(rd, 32'h0);
        // Collision stops counting but still latches
        src.rx_collision <= 1'b1;
        pulse(14, 1);
        @(posedge ref_clk);
        src.rx_collision <= 1'b0;
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd[13], 1'b1);
        axi_read(ADDR_RXERR_CNT, rd, rs);
        check(rd, 32'h0);
        // Saturation at the counter maximum
        axi_write(ADDR_RXERR_CNT, 32'hFE, rs);
        pulse(14, 3);
        axi_read(ADDR_RXERR_CNT, rd, rs);
        check(rd, {24'h0, CNT_MAX});
        // False carrier latch and counter
        pulse(12, 2);
        axi_read(ADDR_RXERR_CNT, rd, rs);
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd[11], 1'b1);
        axi_read(ADDR_FC_CNT, rd, rs);
        check(rd, 32'h2);
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd[11], 1'b0);
        axi_write(ADDR_FC_CNT, 32'h5, rs);
        axi_read(ADDR_FC_CNT, rd, rs);
        check(rd, 32'h5);
        // Remote fault: set by partner, held, cleared by basic status read
        pulse(7, 1);
        axi_read(ADDR_SUMMARY, rd, rs);
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd[6], 1'b1);
        pulse(6, 1);
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd[6], 1'b0);
        pulse(7, 1);
        do_reset();
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd, 32'h0);
        // Writes to the summary have no effect; unmapped places refused
        axi_write(ADDR_SUMMARY, 32'hFFFFFFFF, rs);
        check(rs, RESP_OKAY);
        axi_read(ADDR_SUMMARY, rd, rs);
        check(rd, 32'h0600);
        axi_write(8'h44, 32'h1, rs);
        check(rs, RESP_SLVERR);
        axi_read(8'h44, rd, rs);
        check(rd, 32'h0);
        check(rs, RESP_SLVERR);
        complete_run();
    end

endmodule : tb_pss_top
